// [core/tmr_pkg.sv]
// Package of constants for the task management report and timeouts descriptor block.
// Assumes a single 125 MHz core clock and an AXI4-Lite register master.
package tmr_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] TMR_CTRL_OFS = 8'h00;
  localparam logic [7:0] TMR_STAT_OFS = 8'h04;
  localparam logic [7:0] TMR_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] TMR_IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] TMR_CDB0_OFS = 8'h10;
  localparam logic [7:0] TMR_CDB1_OFS = 8'h14;
  localparam logic [7:0] TMR_CDB2_OFS = 8'h18;
  localparam logic [7:0] TMR_SUPPORT_OFS = 8'h1C;
  localparam logic [7:0] TMR_TO_CFG_OFS = 8'h20;
  localparam logic [7:0] TMR_NOM_TO_OFS = 8'h24;
  localparam logic [7:0] TMR_REC_TO_OFS = 8'h28;
  localparam logic [7:0] TMR_RESULT_OFS = 8'h2C;
  localparam logic [7:0] TMR_DESC0_OFS = 8'h30;
  localparam logic [7:0] TMR_DESC1_OFS = 8'h34;
  localparam logic [7:0] TMR_DESC2_OFS = 8'h38;
  localparam logic [7:0] TMR_DATA_OFS = 8'h3C;
  // ==========================================================
  // Command codes and fields
  localparam logic [7:0] TMR_OP_MAINT_IN = 8'hA3;
  localparam logic [4:0] TMR_SA_REPORT_TMF = 5'h0D;
  localparam logic [7:0] TMR_OP_REQ_SENSE = 8'h03;
  localparam logic [15:0] TMR_DESC_LEN = 16'h000A;
  localparam logic [31:0] TMR_MIN_ALLOC = 32'h0000_0004;
  localparam logic [31:0] TMR_REPORT_LEN = 32'h0000_0004;
  localparam logic [4:0] TMR_MODE_DL = 5'h04;
  localparam logic [4:0] TMR_MODE_DL_SAVE = 5'h05;
  localparam logic [4:0] TMR_MODE_DL_OFS = 5'h06;
  localparam logic [4:0] TMR_MODE_DL_OFS_SAVE = 5'h07;
  localparam logic [4:0] TMR_MODE_DL_DEFER = 5'h0E;
  localparam logic [4:0] TMR_MODE_ACTIVATE = 5'h0F;
  // Sense reporting codes.
  localparam logic [7:0] TMR_STATUS_GOOD = 8'h00;
  localparam logic [7:0] TMR_STATUS_CHECK = 8'h02;
  localparam logic [3:0] TMR_KEY_NONE = 4'h0;
  localparam logic [3:0] TMR_KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] TMR_ASC_NONE = 8'h00;
  localparam logic [7:0] TMR_ASC_INV_FIELD = 8'h24;
  localparam logic [7:0] TMR_ASC_INV_OPCODE = 8'h20;
  // Field positions of the control register.
  localparam int TMR_CTRL_START_BIT = 0;
  localparam int TMR_CTRL_DESC_PRESENT_BIT = 1;
  // Reset values.
  localparam logic [31:0] TMR_SUPPORT_RST = 32'h0000_0000;
  localparam logic [31:0] TMR_TO_CFG_RST = 32'h0000_0000;
  // Interrupt bits.
  localparam int TMR_IRQ_DONE_BIT = 0;
  localparam int TMR_IRQ_CHECK_BIT = 1;
  localparam int TMR_IRQ_W = 2;
endpackage

// [core/tmr_cdb_decode.sv]
// Decoder of the twelve-byte command block window.
// Assumes the CDB bytes are stable in the cycle that they are decoded.
`timescale 1ns/100ps
module tmr_cdb_decode
  import tmr_pkg::*;
(
  input wire logic [95:0] cdb_i,
  output logic is_report_o,
  output logic is_sense_o,
  output logic [31:0] alloc_len_o,
  output logic short_alloc_o,
  output logic [1:0] flag_link_o
);
  wire [7:0] op = cdb_i[7:0];
  wire [4:0] svc = cdb_i[12:8];
  assign is_report_o = (op == TMR_OP_MAINT_IN) && (svc == TMR_SA_REPORT_TMF);
  assign is_sense_o = (op == TMR_OP_REQ_SENSE);
  // Big endian allocation bytes 6 to 9, or byte 4 for sense.
  assign alloc_len_o = is_sense_o ? {24'h00_0000, cdb_i[39:32]} :
                       {cdb_i[55:48], cdb_i[63:56], cdb_i[71:64], cdb_i[79:72]};
  assign short_alloc_o = is_report_o && (alloc_len_o < TMR_MIN_ALLOC);
  assign flag_link_o = is_sense_o ? cdb_i[41:40] : cdb_i[89:88];
endmodule

// [core/tmr_timeout_desc.sv]
// Builder of the twelve-byte command timeouts descriptor.
// Assumes timeouts are supplied already free of outside delays.
`timescale 1ns/100ps
module tmr_timeout_desc
  import tmr_pkg::*;
(
  input wire logic is_wbuf_i,
  input wire logic [4:0] wbuf_mode_i,
  input wire logic defer_event_act_i,
  input wire logic [7:0] access_loss_s_i,
  input wire logic [31:0] nominal_i,
  input wire logic [31:0] recommended_i,
  output logic [95:0] desc_o
);
  // Firmware download modes that use the specific byte.
  wire listed = (wbuf_mode_i >= TMR_MODE_DL && wbuf_mode_i <= TMR_MODE_DL_OFS_SAVE) ||
                (wbuf_mode_i == TMR_MODE_ACTIVATE);
  // Deferred mode only with another activation event.
  wire defer_ok = (wbuf_mode_i == TMR_MODE_DL_DEFER) && defer_event_act_i;
  // Reserved byte unless the command defines it.
  // Seconds of access loss; zero means none given.
  wire [7:0] spec = (is_wbuf_i && (listed || defer_ok)) ? access_loss_s_i : 8'h00;
  // Length, reserved byte, specific byte, then the two timeouts, MSB first.
  assign desc_o = {recommended_i[7:0], recommended_i[15:8], recommended_i[23:16], recommended_i[31:24],
                   nominal_i[7:0], nominal_i[15:8], nominal_i[23:16], nominal_i[31:24],
                   spec, 8'h00, TMR_DESC_LEN[7:0], TMR_DESC_LEN[15:8]};
endmodule

// [core/tmr_core.sv]
// Top of the task management report block with an AXI4-Lite register slave.
// Assumes one core clock; CDB words arrive over the register bus.
`timescale 1ns/100ps
// How it works
// - Reported timeouts run from command start to completion and leave out outside delays.
// - Power transition time is left out of timeouts for power-changing commands.
// - The descriptor starts with length 0Ah, a zero byte 2, nominal in 4-7 and recommended in 8-11.
// - Byte 3 is reserved zero when no command-specific data is defined.
// - For buffer writes byte 3 is filled only for modes 04h to 07h and 0Fh.
// - Mode 0Eh fills byte 3 only when activation comes from another event.
// - Byte 3 holds the longest access-loss time in whole seconds.
// - A zero in byte 3 means no maximum is given.
// - The report is a twelve-byte A3h/0Dh block with allocation in bytes 6-9.
// - An allocation under four ends in check condition, illegal request, invalid field.
// - Byte 0 of the report holds the eight function bits from abort one down to wakeup.
// - Byte 1 holds query attention, query set and nexus reset in bits 2 to 0, rest zero.
// - The sense request is a six-byte 03h block with allocation in byte 4.
// - The descriptor is attached only when the present flag is one.
module tmr_core
  import tmr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic irq_o
);
  import tmr_pkg::*;

  // ==========================================================
  // Registers
  logic [31:0] cdb0_r, cdb1_r, cdb2_r;
  logic [31:0] support_r, to_cfg_r, nom_r, rec_r;
  logic desc_present_r;
  logic busy_r;
  logic [31:0] result_r;
  logic [31:0] data_r;
  logic [95:0] desc_r;
  logic [TMR_IRQ_W-1:0] irq_stat_r, irq_mask_r;
  logic [7:0] awaddr_r, araddr_r;
  logic aw_have_r, w_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  typedef enum logic [1:0] {TMR_IDLE, TMR_EXEC, TMR_DONE} tmr_state_t;
  tmr_state_t state_r;

  // ==========================================================
  // Command decode and descriptor build
  wire is_report;
  wire is_sense;
  wire [31:0] alloc_len;
  wire short_alloc;
  wire [1:0] flag_link;
  wire [95:0] desc_w;

  tmr_cdb_decode u_dec (
    .cdb_i({cdb2_r, cdb1_r, cdb0_r}),
    .is_report_o(is_report),
    .is_sense_o(is_sense),
    .alloc_len_o(alloc_len),
    .short_alloc_o(short_alloc),
    .flag_link_o(flag_link)
  );

  // Timeouts are loaded by firmware as pure processing time.
  // Firmware writes them without any spin-up allowance.
  tmr_timeout_desc u_desc (
    .is_wbuf_i(to_cfg_r[15]),
    .wbuf_mode_i(to_cfg_r[12:8]),
    .defer_event_act_i(to_cfg_r[16]),
    .access_loss_s_i(to_cfg_r[7:0]),
    .nominal_i(nom_r),
    .recommended_i(rec_r),
    .desc_o(desc_w)
  );

  // Function bits in byte 0; three bits in byte 1, rest reserved.
  wire [31:0] report_word = {16'h0000, 5'h00, support_r[10:8], support_r[7:0]};

  // Truncate to the allocation length, byte by byte.
  function automatic logic [31:0] trunc_word(input logic [31:0] w, input logic [31:0] len);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (len > 32'(i)) begin
        m[8*i +: 8] = 8'hFF;
      end
    end
    return w & m;
  endfunction

  // Result word: status, zero nibble, sense key, additional sense code, byte count.
  function automatic logic [31:0] make_result(input logic [7:0] st, input logic [3:0] key,
                                              input logic [7:0] asc, input logic [7:0] cnt);
    return {st, 4'h0, key, asc, cnt};
  endfunction

  wire [7:0] xfer_len = (alloc_len > TMR_REPORT_LEN) ? TMR_REPORT_LEN[7:0] : alloc_len[7:0];
  wire [31:0] res_nxt = !is_report && !is_sense ?
                        make_result(TMR_STATUS_CHECK, TMR_KEY_ILLEGAL, TMR_ASC_INV_OPCODE, 8'h00) :
                        short_alloc ?
                        make_result(TMR_STATUS_CHECK, TMR_KEY_ILLEGAL, TMR_ASC_INV_FIELD, 8'h00) :
                        is_report ? make_result(TMR_STATUS_GOOD, TMR_KEY_NONE, TMR_ASC_NONE, xfer_len) :
                        make_result(TMR_STATUS_GOOD, TMR_KEY_NONE, TMR_ASC_NONE, 8'h00);
  wire [31:0] data_nxt = (is_report && !short_alloc) ? trunc_word(report_word, alloc_len) : 32'h0000_0000;
  wire check_evt = is_report ? short_alloc : !is_sense;

  // ==========================================================
  // Bus write path
  wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
  wire [7:0] wa = awaddr_r;
  wire wr_ctrl = wr_fire && (wa == TMR_CTRL_OFS);
  // A new start is honoured from idle and after an earlier command has completed.
  wire start_cmd = wr_ctrl && wdata_r[TMR_CTRL_START_BIT] && wstrb_r[0] && (state_r != TMR_EXEC);
  wire wr_known = (wa == TMR_CTRL_OFS) || (wa == TMR_IRQ_MASK_OFS) || (wa == TMR_CDB0_OFS) ||
                  (wa == TMR_CDB1_OFS) || (wa == TMR_CDB2_OFS) || (wa == TMR_SUPPORT_OFS) ||
                  (wa == TMR_TO_CFG_OFS) || (wa == TMR_NOM_TO_OFS) || (wa == TMR_REC_TO_OFS);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Bus read path
  wire rd_fire = s_axi_arvalid_i && arready_r;
  wire [7:0] ra = s_axi_araddr_i;
  wire rd_irq = rd_fire && (ra == TMR_IRQ_STAT_OFS);
  wire [31:0] rd_mux =
    (ra == TMR_CTRL_OFS) ? {30'h0, desc_present_r, 1'b0} :
    (ra == TMR_STAT_OFS) ? {30'h0, state_r == TMR_DONE, busy_r} :
    (ra == TMR_IRQ_STAT_OFS) ? {30'h0, irq_stat_r} :
    (ra == TMR_IRQ_MASK_OFS) ? {30'h0, irq_mask_r} :
    (ra == TMR_CDB0_OFS) ? cdb0_r :
    (ra == TMR_CDB1_OFS) ? cdb1_r :
    (ra == TMR_CDB2_OFS) ? cdb2_r :
    (ra == TMR_SUPPORT_OFS) ? support_r :
    (ra == TMR_TO_CFG_OFS) ? to_cfg_r :
    (ra == TMR_NOM_TO_OFS) ? nom_r :
    (ra == TMR_REC_TO_OFS) ? rec_r :
    (ra == TMR_RESULT_OFS) ? result_r :
    (ra == TMR_DESC0_OFS) ? desc_r[31:0] :
    (ra == TMR_DESC1_OFS) ? desc_r[63:32] :
    (ra == TMR_DESC2_OFS) ? desc_r[95:64] :
    (ra == TMR_DATA_OFS) ? data_r : 32'h0000_0000;
  wire rd_known = (ra <= TMR_DATA_OFS) && (ra[1:0] == 2'b00);

  // ==========================================================
  // Interrupt events
  wire done_evt = (state_r == TMR_EXEC);
  wire [TMR_IRQ_W-1:0] evt = {done_evt && check_evt, done_evt};
  // Set wins over the clear by read.
  wire [TMR_IRQ_W-1:0] irq_stat_nxt = (rd_irq ? {TMR_IRQ_W{1'b0}} : irq_stat_r) | evt;

  // ==========================================================
  // Sequential logic
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
    end else if (clk_en_i) begin
      awready_r <= !aw_have_r && !s_axi_awvalid_i ? 1'b1 : !aw_have_r && !awready_r;
      wready_r <= !w_have_r && !s_axi_wvalid_i ? 1'b1 : !w_have_r && !wready_r;
      if (s_axi_awvalid_i && awready_r) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_i;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_r) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? 2'b00 : 2'b10;
      end else if (bvalid_r && s_axi_bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
    end else if (clk_en_i) begin
      arready_r <= !rvalid_r && !rd_fire;
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_known ? 2'b00 : 2'b10;
      end else if (rvalid_r && s_axi_rready_i) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cdb0_r <= 32'h0000_0000;
      cdb1_r <= 32'h0000_0000;
      cdb2_r <= 32'h0000_0000;
      support_r <= TMR_SUPPORT_RST;
      to_cfg_r <= TMR_TO_CFG_RST;
      nom_r <= 32'h0000_0000;
      rec_r <= 32'h0000_0000;
      desc_present_r <= 1'b0;
      irq_mask_r <= {TMR_IRQ_W{1'b0}};
    end else if (clk_en_i && wr_fire) begin
      if (wa == TMR_CDB0_OFS) cdb0_r <= merge(cdb0_r, wdata_r, wstrb_r);
      if (wa == TMR_CDB1_OFS) cdb1_r <= merge(cdb1_r, wdata_r, wstrb_r);
      if (wa == TMR_CDB2_OFS) cdb2_r <= merge(cdb2_r, wdata_r, wstrb_r);
      if (wa == TMR_SUPPORT_OFS) support_r <= merge(support_r, wdata_r, wstrb_r);
      if (wa == TMR_TO_CFG_OFS) to_cfg_r <= merge(to_cfg_r, wdata_r, wstrb_r);
      if (wa == TMR_NOM_TO_OFS) nom_r <= merge(nom_r, wdata_r, wstrb_r);
      if (wa == TMR_REC_TO_OFS) rec_r <= merge(rec_r, wdata_r, wstrb_r);
      if (wr_ctrl && wstrb_r[0]) desc_present_r <= wdata_r[TMR_CTRL_DESC_PRESENT_BIT];
      if (wa == TMR_IRQ_MASK_OFS && wstrb_r[0]) irq_mask_r <= wdata_r[TMR_IRQ_W-1:0];
    end
  end

  // Command sequencer: one cycle of evaluation, then results stand.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_r <= TMR_IDLE;
      busy_r <= 1'b0;
      result_r <= 32'h0000_0000;
      data_r <= 32'h0000_0000;
      desc_r <= 96'h0;
      irq_stat_r <= {TMR_IRQ_W{1'b0}};
      irq_r <= 1'b0;
    end else if (clk_en_i) begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
      case (state_r)
        TMR_IDLE, TMR_DONE: begin
          if (start_cmd) begin
            state_r <= TMR_EXEC;
            busy_r <= 1'b1;
          end
        end
        TMR_EXEC: begin
          result_r <= res_nxt;
          data_r <= data_nxt;
          // Descriptor only when the present flag is set.
          desc_r <= desc_present_r ? desc_w : 96'h0;
          busy_r <= 1'b0;
          state_r <= TMR_DONE;
        end
        default: state_r <= TMR_IDLE;
      endcase
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign irq_o = irq_r;
endmodule

// [verification/tmr_core_assertions.sv]
// Concurrent checks on the register-bus ports of the task management report block.
// Assumes clk_en_i stays high while the bench runs commands.
`timescale 1ns/100ps
module tmr_core_assertions
  import tmr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic irq_o
);
  // ==========================================================
  // Read address tracking and properties
  logic [7:0] ra_r;
  always_ff @(posedge core_clk_i) begin
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      ra_r <= s_axi_araddr_i;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_bhold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped before taken");
  property p_rhold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data changed before taken");
  property p_rd_ans;
    s_axi_arvalid_i && s_axi_arready_o && clk_en_i |=> s_axi_rvalid_o;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_unmapped;
    s_axi_rvalid_o && ra_r >= 8'h40 |-> s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_chk_key;
    s_axi_rvalid_o && ra_r == TMR_RESULT_OFS && s_axi_rdata_o[31:24] == TMR_STATUS_CHECK
      |-> s_axi_rdata_o[19:16] == TMR_KEY_ILLEGAL;
  endproperty
  a_chk_key: assert property (p_chk_key) else $error("check condition without illegal request key");
  property p_good_cnt;
    s_axi_rvalid_o && ra_r == TMR_RESULT_OFS && s_axi_rdata_o[31:24] == TMR_STATUS_GOOD
      |-> s_axi_rdata_o[7:0] <= 8'h04 && s_axi_rdata_o[19:8] == 12'h000;
  endproperty
  a_good_cnt: assert property (p_good_cnt) else $error("good result count too large");
  property p_data_rsv;
    s_axi_rvalid_o && ra_r == TMR_DATA_OFS |-> s_axi_rdata_o[31:11] == 21'h000000;
  endproperty
  a_data_rsv: assert property (p_data_rsv) else $error("reserved report bits set");
  property p_desc_len;
    s_axi_rvalid_o && ra_r == TMR_DESC0_OFS && s_axi_rdata_o != 32'h0000_0000
      |-> s_axi_rdata_o[23:0] == 24'h000A00;
  endproperty
  a_desc_len: assert property (p_desc_len) else $error("descriptor length or reserved byte wrong");
  c_check: cover property (s_axi_rvalid_o && ra_r == TMR_RESULT_OFS && s_axi_rdata_o[31:24] == TMR_STATUS_CHECK);
  c_irq: cover property ($rose(irq_o));
  c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'b10);
endmodule
bind tmr_core tmr_core_assertions u_chk (.core_clk_i, .rst_n_i, .clk_en_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .irq_o);

// [verification/tmr_host_model.sv]
// Initiator model that issues command blocks over the register bus.
// Assumes an AXI4-Lite slave; response readiness is delayed at random.
`timescale 1ns/100ps
module tmr_host_model (
  input wire logic clk_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // ==========================================================
  // Bus cycles
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= 4'hF;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        aw_ok = 1'b1;
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        w_ok = 1'b1;
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
    end
    repeat ($urandom_range(0, 2)) @(posedge clk_i);
    bready_o <= 1'b1;
    do @(posedge clk_i); while (!bvalid_i);
    resp = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    do @(posedge clk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    araddr_o <= ~a;
    repeat ($urandom_range(0, 2)) @(posedge clk_i);
    rready_o <= 1'b1;
    do @(posedge clk_i); while (!rvalid_i);
    d = rdata_i;
    resp = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the task management report block.
// Assumes the host model drives every register-bus cycle.
`timescale 1ns/100ps
module tb_top;
  import tmr_pkg::*;
  logic core_clk_i, rst_n_i, clk_en_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, irq_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, sup, res, d, al, nom, rec, cfg;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic [4:0] mo;
  logic df, wb, dp;
  int err_total, checks_done, cycles;
  logic [31:0] als [5];
  always #4 core_clk_i = ~core_clk_i;
  tmr_core u_dut (.core_clk_i, .rst_n_i, .clk_en_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .irq_o);
  tmr_host_model hm (.clk_i(core_clk_i), .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
    .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i), .wvalid_o(s_axi_wvalid_i),
    .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o), .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i),
    .araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));
  // ==========================================================
  // Checking helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] cs_exp(logic w, logic [4:0] m, logic f, logic [7:0] s);
    if (w && (m inside {TMR_MODE_DL, TMR_MODE_DL_SAVE, TMR_MODE_DL_OFS, TMR_MODE_DL_OFS_SAVE, TMR_MODE_ACTIVATE}
        || (m == TMR_MODE_DL_DEFER && f))) begin
      return s;
    end
    return 8'h00;
  endfunction
  function automatic logic [31:0] bsw(logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  task automatic cmd(input logic [31:0] c0, c1, c2, input logic p, output logic [31:0] q);
    logic [31:0] s;
    hm.wr(TMR_CDB0_OFS, c0, r);
    hm.wr(TMR_CDB1_OFS, c1, r);
    hm.wr(TMR_CDB2_OFS, c2, r);
    hm.wr(TMR_CTRL_OFS, {30'h0, p, 1'b1}, r);
    repeat (2) @(posedge core_clk_i);
    hm.rd(TMR_STAT_OFS, s, r);
    chk("status done", 32'h2, {30'h0, s[1:0]});
    hm.rd(TMR_RESULT_OFS, q, r);
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    core_clk_i = 1'b0;
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    cycles = 0;
    void'($urandom(89150));
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    hm.rd(8'h40, d, r);
    chk("unmapped read", 32'h2, {30'h0, r});
    hm.wr(8'h44, $urandom, r);
    chk("unmapped write", 32'h2, {30'h0, r});
    $display("test unmapped done");
    sup = {21'h0, 11'($urandom)};
    hm.wr(TMR_SUPPORT_OFS, sup, r);
    als = '{32'h0, 32'h3, 32'h4, 32'hFFFF_FFFF, 32'($urandom_range(5, 4096))};
    foreach (als[i]) begin
      al = als[i];
      cmd(32'h0000_0DA3, {al[23:16], al[31:24], 16'h0}, {16'h0, al[7:0], al[15:8]}, 1'b0, res);
      if (al < 4) begin
        chk("short allocation", 32'h0205_2400, {res[31:8], 8'h00});
      end else begin
        chk("report result", 32'h0000_0004, res);
        hm.rd(TMR_DATA_OFS, d, r);
        chk("report data", sup, d);
      end
    end
    $display("test report done");
    cmd(32'h0000_0003, {16'h0, 6'h0, 2'($urandom), 8'($urandom)}, 32'h0, 1'b0, res);
    chk("sense result", 32'h0, res);
    cmd(32'h0000_0012, 32'h0, 32'h0, 1'b0, res);
    chk("unknown opcode", 32'h0205_2000, {res[31:8], 8'h00});
    $display("test decode done");
    for (int i = 0; i < 20; i++) begin
      mo = (i < 17) ? i[4:0] : TMR_MODE_DL_DEFER;
      df = (i < 17) ? 1'($urandom_range(0, 1)) : i[0];
      wb = (i != 19);
      dp = (i != 3);
      nom = $urandom;
      rec = $urandom;
      cfg = {15'h0, df, wb, 2'h0, mo, (i == 4) ? 8'h00 : 8'($urandom_range(1, 255))};
      hm.wr(TMR_TO_CFG_OFS, cfg, r);
      hm.wr(TMR_NOM_TO_OFS, nom, r);
      hm.wr(TMR_REC_TO_OFS, rec, r);
      cmd(32'h0000_0DA3, 32'h0, 32'h0000_0400, dp, res);
      hm.rd(TMR_DESC0_OFS, d, r);
      chk("desc word0", dp ? {cs_exp(wb, mo, df, cfg[7:0]), 24'h000A00} : 32'h0, d);
      hm.rd(TMR_DESC1_OFS, d, r);
      chk("desc nominal", dp ? bsw(nom) : 32'h0, d);
      hm.rd(TMR_DESC2_OFS, d, r);
      chk("desc recommended", dp ? bsw(rec) : 32'h0, d);
    end
    $display("test descriptor done");
    hm.rd(TMR_IRQ_STAT_OFS, d, r);
    hm.wr(TMR_IRQ_MASK_OFS, 32'h2, r);
    cmd(32'h0000_0DA3, 32'h0, 32'h0, 1'b0, res);
    chk("irq raised", 32'h1, {31'h0, irq_o});
    hm.rd(TMR_IRQ_STAT_OFS, d, r);
    chk("irq status", 32'h3, d);
    repeat (2) @(posedge core_clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    cmd(32'h0000_0DA3, 32'h0, 32'h0000_0400, 1'b0, res);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    hm.rd(TMR_IRQ_STAT_OFS, d, r);
    chk("irq status masked", 32'h1, d);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule
